// >>> common/wdt_cfg.svh
// Register offsets, field positions, reset values and timing constants of the watchdog
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
`define WDT_OFF_CTRL    12'h000
`define WDT_OFF_RELOAD  12'h004
`define WDT_OFF_FEED1   12'h008
`define WDT_OFF_FEED2   12'h00C
`define WDT_OFF_CLOCK_CONTROL_REG  12'h010
`define WDT_OFF_IEN     12'h014
`define WDT_OFF_STATUS  12'h018
`define WDT_B_CLKSEL    0
`define WDT_B_TOF       1
`define WDT_B_RUN       2
`define WDT_B_PRE_LO    5
`define WDT_B_PRE_HI    7
`define WDT_B_XTAL      4
`define WDT_B_IEN       6
`define WDT_RST_CTRL    8'hE5
`define WDT_RST_RELOAD  8'hFF
`define WDT_FEED1_VAL   8'hA5
`define WDT_FEED2_VAL   8'h5A
`define WDT_PRE_BASE    5
`define WDT_SYNC_LEN    2
`endif

// >>> common/wdt_pkg.sv
// Types shared by the watchdog files
package wdt_pkg;
  typedef enum logic [1:0] {
    WDT_SRC_PCLK,
    WDT_SRC_WDOSC,
    WDT_SRC_XTAL
  } wdt_src_t;
  typedef enum logic [1:0] {
    WDT_SW_IDLE,
    WDT_SW_DROP,
    WDT_SW_TAKE
  } wdt_sw_t;
endpackage

// >>> rtl/wdt_clk_switch.sv
// Glitch-free source switch: deselect old source, then select new one
`include "wdt_cfg.svh"
module wdt_clk_switch (
  input  wire logic     clk_i,
  input  wire logic     arst_n_i,
  input  wire logic     ce_i,
  input  wire wdt_pkg::wdt_src_t src_req_i,
  input  wire logic     cpu_clk_on_i,
  input  wire logic     tick_pclk_i,
  input  wire logic     tick_wdosc_i,
  input  wire logic     tick_xtal_i,
  output logic          tick_o,
  output logic          busy_o
);
  import wdt_pkg::*;

  wdt_src_t src_reg;
  wdt_src_t tgt_reg;
  wdt_sw_t  st_reg;
  logic [1:0] cnt_reg;
  logic old_tick;
  logic new_tick;

  always_comb begin
    case (src_reg)
      WDT_SRC_PCLK:  old_tick = tick_pclk_i;
      WDT_SRC_WDOSC: old_tick = tick_wdosc_i;
      WDT_SRC_XTAL:  old_tick = tick_xtal_i;
      default:       old_tick = 1'b0;
    endcase
    case (tgt_reg)
      WDT_SRC_PCLK:  new_tick = tick_pclk_i;
      WDT_SRC_WDOSC: new_tick = tick_wdosc_i;
      WDT_SRC_XTAL:  new_tick = tick_xtal_i;
      default:       new_tick = 1'b0;
    endcase
  end

  // Two old-clock ticks to drop, then two new-clock ticks to take
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg  <= WDT_SW_IDLE;
      src_reg <= WDT_SRC_WDOSC;
      tgt_reg <= WDT_SRC_WDOSC;
      cnt_reg <= 2'h0;
      tick_o  <= 1'b0;
      busy_o  <= 1'b0;
    end else if (ce_i) begin
      tick_o <= 1'b0;
      case (st_reg)
        WDT_SW_IDLE: begin
          tick_o <= old_tick;
          busy_o <= 1'b0;
          if (src_req_i != src_reg) begin
            tgt_reg <= src_req_i;
            cnt_reg <= 2'h0;
            busy_o  <= 1'b1;
            st_reg  <= WDT_SW_DROP;
          end
        end
        WDT_SW_DROP: begin
          // A stopped old clock stalls the switch here
          if (old_tick) begin
            if (cnt_reg == 2'(`WDT_SYNC_LEN - 1)) begin
              cnt_reg <= 2'h0;
              st_reg  <= WDT_SW_TAKE;
            end else begin
              cnt_reg <= cnt_reg + 2'h1;
            end
          end
        end
        WDT_SW_TAKE: begin
          // The oscillator is never taken while the cpu clock is off
          if (new_tick && (cpu_clk_on_i || tgt_reg != WDT_SRC_WDOSC)) begin
            if (cnt_reg == 2'(`WDT_SYNC_LEN - 1)) begin
              src_reg <= tgt_reg;
              st_reg  <= WDT_SW_IDLE;
            end else begin
              cnt_reg <= cnt_reg + 2'h1;
            end
          end
        end
        default: st_reg <= WDT_SW_IDLE;
      endcase
    end
  end

  sw_gap_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st_reg != WDT_SW_IDLE) |-> !tick_o) else $error("tick leaked during switch");
endmodule // wdt_clk_switch

// >>> rtl/wdt_timer.sv
// Watchdog in timer mode: clock source select, prescaler, down counter, APB registers
`include "wdt_cfg.svh"
module wdt_timer
#(
  parameter int unsigned CNT_W = 8,
  parameter int unsigned PRE_W = 12
)(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        tick_pclk_i,
  input  wire logic        tick_wdosc_i,
  input  wire logic        tick_xtal_i,
  input  wire logic        power_down_i,
  input  wire logic        cpu_clk_on_i,
  output logic             irq_o,
  output logic             wake_o,
  output logic             wdosc_keep_on_o,
  output logic             xtal_keep_on_o
);
  import wdt_pkg::*;

  logic [7:0]       ctrl_reg;
  logic [7:0]       shadow_reg;
  logic             ctrl_pend_reg;
  logic [7:0]       reload_reg;
  logic             xtal_sel_reg;
  logic             ien_reg;
  logic             feed_armed_reg;
  wdt_src_t         src_cfg_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [PRE_W-1:0] pre_reg;
  logic             extra_reg;
  logic [1:0]       pd_sync_reg;
  logic [1:0]       cpu_sync_reg;
  logic             wd_tick;
  logic             sw_busy;
  logic             wr;
  logic             rd;
  logic             feed_ok;
  logic             uflow;
  logic             pre_hit;
  logic [2:0]       tap;
  wdt_src_t         src_want;

  assign wr  = psel_i && penable_i && pwrite_i;
  assign rd  = psel_i && !penable_i && !pwrite_i;
  assign tap = shadow_reg[`WDT_B_PRE_HI:`WDT_B_PRE_LO];

  // Pins from the power controller cross into this domain
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pd_sync_reg  <= 2'h0;
      cpu_sync_reg <= 2'h3;
    end else if (ce_i) begin
      pd_sync_reg  <= {pd_sync_reg[0], power_down_i};
      cpu_sync_reg <= {cpu_sync_reg[0], cpu_clk_on_i};
    end
  end

  always_comb begin
    if (xtal_sel_reg) begin
      src_want = WDT_SRC_XTAL;
    end else if (ctrl_reg[`WDT_B_CLKSEL]) begin
      src_want = WDT_SRC_WDOSC;
    end else begin
      src_want = WDT_SRC_PCLK;
    end
  end

  // Second write completes a feed only right after a correct first write
  assign feed_ok = wr && (paddr_i == `WDT_OFF_FEED2) && feed_armed_reg
                   && (pwdata_i[7:0] == `WDT_FEED2_VAL);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      feed_armed_reg <= 1'b0;
    end else if (ce_i && wr) begin
      // Any other write breaks the sequence, silently
      feed_armed_reg <= (paddr_i == `WDT_OFF_FEED1) && (pwdata_i[7:0] == `WDT_FEED1_VAL);
    end
  end

  // Source setting is latched into the switch only on a feed
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_cfg_reg <= WDT_SRC_WDOSC;
    end else if (ce_i && feed_ok) begin
      src_cfg_reg <= src_want;
    end
  end

  wdt_clk_switch u_switch (
    .clk_i        (clk_i),
    .arst_n_i     (arst_n_i),
    .ce_i         (ce_i),
    .src_req_i    (src_cfg_reg),
    .cpu_clk_on_i (cpu_sync_reg[1]),
    .tick_pclk_i  (tick_pclk_i && !pd_sync_reg[1]),
    .tick_wdosc_i (tick_wdosc_i),
    .tick_xtal_i  (tick_xtal_i),
    .tick_o       (wd_tick),
    .busy_o       (sw_busy)
  );

  // Register writes; clock-select and run bits live in the control register, the crystal select bit in the clock control register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg     <= `WDT_RST_CTRL;
      reload_reg   <= `WDT_RST_RELOAD;
      xtal_sel_reg <= 1'b0;
      ien_reg      <= 1'b0;
    end else if (ce_i) begin
      if (wr && paddr_i == `WDT_OFF_CTRL) begin
        ctrl_reg <= pwdata_i[7:0];
        // A zero clears the flag but an underflow in the same cycle wins
        ctrl_reg[`WDT_B_TOF] <= uflow || (pwdata_i[`WDT_B_TOF] && ctrl_reg[`WDT_B_TOF]);
      end else if (uflow) begin
        ctrl_reg[`WDT_B_TOF] <= 1'b1;
      end
      if (wr && paddr_i == `WDT_OFF_RELOAD) begin
        reload_reg <= pwdata_i[7:0];
      end
      if (wr && paddr_i == `WDT_OFF_CLOCK_CONTROL_REG) begin
        xtal_sel_reg <= pwdata_i[`WDT_B_XTAL];
      end
      if (wr && paddr_i == `WDT_OFF_IEN) begin
        ien_reg <= pwdata_i[`WDT_B_IEN];
      end
    end
  end

  // Shadow control follows the control register one watchdog tick later
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shadow_reg    <= `WDT_RST_CTRL;
      ctrl_pend_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr && paddr_i == `WDT_OFF_CTRL) begin
        ctrl_pend_reg <= 1'b1;
      end else if (wd_tick && ctrl_pend_reg) begin
        shadow_reg    <= ctrl_reg;
        ctrl_pend_reg <= 1'b0;
      end
    end
  end

  // Prescaler divides by 2^(5+tap); counter steps when it wraps
  assign pre_hit = (pre_reg == PRE_W'((1 << (`WDT_PRE_BASE + 32'(tap))) - 1));
  // One extra tick after counter reaches zero gives the trailing +1
  assign uflow   = wd_tick && extra_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_reg   <= '0;
      cnt_reg   <= CNT_W'(`WDT_RST_RELOAD);
      extra_reg <= 1'b0;
    end else if (ce_i) begin
      if (feed_ok) begin
        pre_reg   <= '0;
        cnt_reg   <= reload_reg;
        extra_reg <= 1'b0;
      end else if (wd_tick && shadow_reg[`WDT_B_RUN]) begin
        if (extra_reg) begin
          extra_reg <= 1'b0;
          pre_reg   <= '0;
          cnt_reg   <= reload_reg;
        end else if (pre_hit) begin
          pre_reg <= '0;
          if (cnt_reg == '0) begin
            extra_reg <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end
        end else begin
          pre_reg <= pre_reg + PRE_W'(1);
        end
      end
    end
  end

  // Outputs and APB read data
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o           <= 1'b0;
      wake_o          <= 1'b0;
      wdosc_keep_on_o <= 1'b1;
      xtal_keep_on_o  <= 1'b1;
      prdata_o        <= 32'h0;
      pready_o        <= 1'b0;
      pslverr_o       <= 1'b0;
    end else if (ce_i) begin
      irq_o           <= ien_reg && ctrl_reg[`WDT_B_TOF];
      wake_o          <= uflow && pd_sync_reg[1];
      wdosc_keep_on_o <= (src_cfg_reg == WDT_SRC_WDOSC) || sw_busy;
      xtal_keep_on_o  <= (src_cfg_reg != WDT_SRC_PCLK) || sw_busy;
      pready_o        <= psel_i && !penable_i;
      pslverr_o       <= 1'b0;
      if (rd) begin
        case (paddr_i)
          `WDT_OFF_CTRL:   prdata_o <= {24'h0, ctrl_reg[7:5], 2'h0, ctrl_reg[2:0]};
          `WDT_OFF_RELOAD: prdata_o <= {24'h0, reload_reg};
          `WDT_OFF_CLOCK_CONTROL_REG: prdata_o <= 32'(xtal_sel_reg) << `WDT_B_XTAL;
          `WDT_OFF_IEN:    prdata_o <= 32'(ien_reg) << `WDT_B_IEN;
          `WDT_OFF_STATUS: prdata_o <= {20'h0, sw_busy, 1'b0, src_cfg_reg, cnt_reg};
          default: begin
            prdata_o  <= 32'h0;
            pslverr_o <= 1'b1;
          end
        endcase
      end
    end
  end

  tof_set_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && uflow |=> ctrl_reg[`WDT_B_TOF]) else $error("underflow lost");
  tof_clr_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && wr && paddr_i == `WDT_OFF_CTRL && !pwdata_i[`WDT_B_TOF] && !uflow
    |=> !ctrl_reg[`WDT_B_TOF]) else $error("flag not cleared");
  irq_req_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && ien_reg && ctrl_reg[`WDT_B_TOF] |=> irq_o) else $error("no interrupt");
  reload_uf_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && uflow && !feed_ok |=> cnt_reg == $past(reload_reg)) else $error("no reload");
  feed_load_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && feed_ok |=> cnt_reg == $past(reload_reg) && pre_reg == '0) else $error("feed no load");
  src_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !(ce_i && feed_ok) |=> $stable(src_cfg_reg)) else $error("source changed without feed");
  bad_feed_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && wr && paddr_i == `WDT_OFF_FEED2 && !feed_armed_reg |=> $stable(cnt_reg) || $past(wd_tick))
    else $error("bad feed acted");
  wake_pd_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && uflow && pd_sync_reg[1] |=> wake_o) else $error("no wake");
  xtal_pick_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && feed_ok && xtal_sel_reg |=> src_cfg_reg == WDT_SRC_XTAL) else $error("crystal not chosen");
  pd_stop_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    pd_sync_reg[1] && src_cfg_reg == WDT_SRC_PCLK && !sw_busy |-> !wd_tick) else $error("counting in power-down");

  // Shadow copy and counting path, step by step
  shadow_copy_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && wd_tick && ctrl_pend_reg && !(wr && paddr_i == `WDT_OFF_CTRL) |=> shadow_reg == $past(ctrl_reg))
    else $error("shadow not updated");
  pre_step_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && wd_tick && shadow_reg[`WDT_B_RUN] && !feed_ok && !extra_reg && !pre_hit |=> pre_reg == $past(pre_reg) + PRE_W'(1))
    else $error("prescaler did not step");
  cnt_step_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && wd_tick && shadow_reg[`WDT_B_RUN] && !feed_ok && !extra_reg && pre_hit && cnt_reg != '0
    |=> cnt_reg == $past(cnt_reg) - CNT_W'(1)) else $error("counter did not step");
  zero_arm_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && wd_tick && shadow_reg[`WDT_B_RUN] && !feed_ok && !extra_reg && pre_hit && cnt_reg == '0
    |=> extra_reg) else $error("trailing tick not armed");
  run_stop_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && !shadow_reg[`WDT_B_RUN] && !feed_ok |=> $stable(cnt_reg) && $stable(pre_reg))
    else $error("counting while stopped");
  // A low clock enable must leave the counter, control and shadow registers untouched
  freeze_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !ce_i |=> $stable(cnt_reg) && $stable(ctrl_reg) && $stable(shadow_reg))
    else $error("state moved while frozen");

  // Source choice on a feed
  pclk_pick_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && feed_ok && !xtal_sel_reg && !ctrl_reg[`WDT_B_CLKSEL] |=> src_cfg_reg == WDT_SRC_PCLK)
    else $error("peripheral clock not chosen");
  osc_pick_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && feed_ok && !xtal_sel_reg && ctrl_reg[`WDT_B_CLKSEL] |=> src_cfg_reg == WDT_SRC_WDOSC)
    else $error("oscillator not chosen");

  // Outputs
  irq_off_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && !ien_reg |=> !irq_o)
    else $error("interrupt while disabled");
  osc_keep_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && src_cfg_reg == WDT_SRC_WDOSC |=> wdosc_keep_on_o && xtal_keep_on_o)
    else $error("oscillators released");
  wake_only_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && !(uflow && pd_sync_reg[1]) |=> !wake_o)
    else $error("spurious wake");
  ready_pulse_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && pready_o |=> !pready_o)
    else $error("ready held too long");
endmodule // wdt_timer

// >>> test/wdt_timer_tb_top.sv
// Self-checking testbench for the watchdog timer-mode block over APB
`include "wdt_cfg.svh"
module wdt_timer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_i;
  logic        arst_n_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [2:0]  tk;
  logic        power_down;
  logic        cpu_on;
  logic        irq_o;
  logic        wake_o;
  logic        wdosc_keep_on_o;
  logic        xtal_keep_on_o;
  logic [31:0] rdata;
  logic        rerr;
  logic        woke;
  int          err_count;
  int          samples_checked;

  wdt_timer wdt_timer_inst (
    .clk_i          (clk_i),
    .arst_n_i       (arst_n_i),
    .ce_i           (1'b1),
    .psel_i         (psel),
    .penable_i      (penable),
    .pwrite_i       (pwrite),
    .paddr_i        (paddr),
    .pwdata_i       (pwdata),
    .prdata_o       (prdata_o),
    .pready_o       (pready_o),
    .pslverr_o      (pslverr_o),
    .tick_pclk_i    (tk[0]),
    .tick_wdosc_i   (tk[1]),
    .tick_xtal_i    (tk[2]),
    .power_down_i   (power_down),
    .cpu_clk_on_i   (cpu_on),
    .irq_o          (irq_o),
    .wake_o         (wake_o),
    .wdosc_keep_on_o(wdosc_keep_on_o),
    .xtal_keep_on_o (xtal_keep_on_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Wake is a one-cycle pulse, so it is latched here rather than polled
  always @(posedge clk_i) begin
    if (wake_o === 1'b1) woke <= 1'b1;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen high at a falling edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int   n;
    logic seen;
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    // Registered outputs are settled mid-cycle and hold through the next rising edge
    do begin
      @(negedge clk_i);
      seen  = pready_o;
      rdata = prdata_o;
      rerr  = pslverr_o;
      @(posedge clk_i);
      n++;
    end while (seen !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic feed();
    wr(`WDT_OFF_FEED1, `WDT_FEED1_VAL);
    wr(`WDT_OFF_FEED2, `WDT_FEED2_VAL);
  endtask

  // One pulse per source edge, then time for flag and irq registers to settle
  task automatic tick(input int s, input int n);
    repeat (n) begin
      @(posedge clk_i);
      tk[s] <= 1'b1;
      @(posedge clk_i);
      tk[s] <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask

  task automatic src_is(input logic [1:0] s, input logic busy);
    rd(`WDT_OFF_STATUS);
    chk({30'h0, rdata[9:8]}, {30'h0, s});
    chk({31'h0, rdata[11]}, {31'h0, busy});
  endtask

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    tk = 3'h0; power_down = 1'b0; cpu_on = 1'b1; woke = 1'b0;
    err_count = 0; samples_checked = 0;
    arst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(`WDT_OFF_CTRL);   chk(rdata, 32'hE5);
    rd(`WDT_OFF_RELOAD); chk(rdata, 32'hFF);
    src_is(2'h1, 1'b0);
    rd(12'h01C); chk(rdata, 32'h0); chk({31'h0, rerr}, 32'h1);
    // Prescale 0 and reload 0 give the shortest timeout
    wr(`WDT_OFF_CTRL, 8'h05); tick(1, 1); wr(`WDT_OFF_RELOAD, 8'h00); feed();
    tick(1, 32); rd(`WDT_OFF_CTRL); chk(rdata, 32'h05);
    tick(1, 1);  rd(`WDT_OFF_CTRL); chk(rdata, 32'h07);
    chk({31'h0, irq_o}, 32'h0);
    wr(`WDT_OFF_IEN, 8'h40); repeat (3) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(`WDT_OFF_CTRL, 8'h05); repeat (3) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    tick(1, 31); chk({31'h0, irq_o}, 32'h0);
    tick(1, 3);  chk({31'h0, irq_o}, 32'h1);
    // A wrong second feed byte must not restart the count
    wr(`WDT_OFF_CTRL, 8'h05); feed(); tick(1, 20);
    wr(`WDT_OFF_FEED1, 8'hA5); wr(`WDT_OFF_FEED2, 8'h00);
    tick(1, 12); chk({31'h0, irq_o}, 32'h0);
    tick(1, 1);  chk({31'h0, irq_o}, 32'h1);
    wr(`WDT_OFF_CTRL, 8'h05); feed(); tick(1, 20); feed();
    tick(1, 32); chk({31'h0, irq_o}, 32'h0);
    tick(1, 1);  chk({31'h0, irq_o}, 32'h1);
    wr(`WDT_OFF_CTRL, 8'h05); feed();
    power_down <= 1'b1; repeat (4) @(posedge clk_i);
    chk({30'h0, wdosc_keep_on_o, xtal_keep_on_o}, 32'h3);
    tick(1, 33); chk({31'h0, woke}, 32'h1);
    power_down <= 1'b0;
    // Switch to the peripheral clock: held until the feed
    wr(`WDT_OFF_CTRL, 8'h04); tick(1, 1);
    src_is(2'h1, 1'b0);
    feed(); tick(1, 1); src_is(2'h0, 1'b1);
    tick(1, 1); tick(0, 2); src_is(2'h0, 1'b0);
    chk({31'h0, wdosc_keep_on_o}, 32'h0);
    power_down <= 1'b1; repeat (4) @(posedge clk_i);
    tick(0, 40); chk({31'h0, irq_o}, 32'h0);
    power_down <= 1'b0; repeat (4) @(posedge clk_i);
    tick(0, 40); chk({31'h0, irq_o}, 32'h1);
    wr(`WDT_OFF_CTRL, 8'h04); wr(`WDT_OFF_CLOCK_CONTROL_REG, 8'h10); feed();
    tick(0, 2); tick(2, 2); src_is(2'h2, 1'b0);
    // With the cpu clock stopped the oscillator must not be taken
    cpu_on <= 1'b0; repeat (4) @(posedge clk_i);
    wr(`WDT_OFF_CTRL, 8'h05); tick(2, 1); wr(`WDT_OFF_CLOCK_CONTROL_REG, 8'h00); feed();
    tick(2, 2); tick(1, 4); src_is(2'h1, 1'b1);
    cpu_on <= 1'b1; repeat (4) @(posedge clk_i);
    tick(1, 2); src_is(2'h1, 1'b0);
    give_verdict();
  end

  // The sequence takes roughly 1600 cycles; over twelve times that is a hang
  initial begin
    #80000;
    err_count++;
    give_verdict();
  end
endmodule // wdt_timer_tb_top
